// [hdl/uif_flag_bit.v]
// one hardware-set, write-one-to-clear sticky flag
`timescale 1ns/1ns
`default_nettype none
`include "uif_consts.vh"

module uif_flag_bit
(
    input  wire core_clk,   // block clock
    input  wire rstn,       // synchronous reset, active low
    input  wire ce,         // clock enable
    input  wire set_in,     // hardware event
    input  wire clr_in,     // software write of one
    output reg  flag_q      // sticky flag
);

    // set wins over clear so no event is lost
    always @(posedge core_clk)
    begin
        if (!rstn)
            flag_q <= 1'b0;
        else if (ce)
        begin
            if (set_in)
                flag_q <= `UIF_ONE_BIT;
            else if (clr_in)
                flag_q <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// [hdl/uif_irq_flags.v]
// usb interrupt and error flag registers with merged interrupt request
//
// Function
// - device mode: bus reset sets event bit 0
// - host mode: detach sets event bit 0
// - attach needs host, 2.5us idle, no SE0
// - clearing token flag advances status fifo
// - only enabled errors set summary flag
// - eight event enables gate same-position flags
// - errors reach irq only via bit 1 enable
// - bit stuff error sets error bit 7
// - bad descriptor address sets error bit 6
// - dma overrun or truncation sets bit 5
// - over sixteen idle bit times sets bit 4
// - partial-byte data field sets bit 3
// - data crc failure sets error bit 2
// - device mode: token crc sets bit 1
// - host mode: end-of-frame error sets bit 1
// - pid check failure sets error bit 0
// - flags hardware set, write-one clear, reset zero
// - eight error enables, same bit positions
// - bits 31 to 8 read zero
// - host enable selects host or device meaning
// - event bit 1 read-only error summary
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "uif_consts.vh"

module uif_irq_flags
(
    input  wire                       core_clk,
    input  wire                       rstn,
    input  wire                       ce,
    input  wire [`UIF_ADDR_W-1:0]     reg_addr,
    input  wire [31:0]                reg_wdata,
    input  wire                       reg_wr,
    input  wire                       reg_rd,
    output reg  [31:0]                reg_rdata_q,
    input  wire                       bus_reset_det,
    input  wire                       detach_det,
    input  wire                       attach_det,
    input  wire                       bus_activity,
    input  wire                       line_se0,
    input  wire                       resume_det,
    input  wire                       idle_det,
    input  wire                       sof_det,
    input  wire                       stall_det,
    input  wire                       token_done,
    input  wire [`UIF_STAT_W-1:0]     token_stat,
    input  wire                       bit_stuff_err,
    input  wire                       bus_matrix_err,
    input  wire                       dma_err,
    input  wire                       eop_seen,
    input  wire                       bit_tick,
    input  wire                       response_seen,
    input  wire                       byte_align_err,
    input  wire                       data_crc_err,
    input  wire                       token_crc_err,
    input  wire                       sof_count_zero,
    input  wire                       xfer_busy,
    input  wire                       pid_check_err,
    output reg                        pkt_reject_q,
    output reg                        host_mode_enable_q,
    output reg                        usb_irq_request_q
);

    ////////////////////////////////////////////////////////////////////////
    // register state
    reg  [`UIF_FLAGS_W-1:0]   evt_en_q;       // event enables
    reg  [`UIF_FLAGS_W-1:0]   err_en_q;       // error enables
    wire [`UIF_FLAGS_W-1:0]   evt_flag;       // event flags
    wire [`UIF_FLAGS_W-1:0]   err_flag;       // error flags
    reg  [`UIF_FLAGS_W-1:0]   evt_set;        // event set terms
    reg  [`UIF_FLAGS_W-1:0]   err_set;        // error set terms
    wire [`UIF_FLAGS_W-1:0]   evt_clr;        // event w1c terms
    wire [`UIF_FLAGS_W-1:0]   err_clr;        // error w1c terms
    wire                      wr_evt;         // write to event flags
    wire                      wr_err;         // write to error flags

    ////////////////////////////////////////////////////////////////////////
    // attach qualification and turnaround timers
    reg  [`UIF_IDLE_CNT_W-1:0] idle_cnt_q;    // cycles of bus silence
    reg  [`UIF_TURN_CNT_W-1:0] turn_cnt_q;    // idle bit times after eop
    reg                        turn_arm_q;    // waiting for a response
    wire                       idle_ok;       // bus quiet long enough
    wire                       turn_timeout;  // turnaround expired

    assign idle_ok = (idle_cnt_q == `UIF_IDLE_CYCLES);

    // count quiet cycles, saturating at the idle time
    always @(posedge core_clk)
    begin
        if (!rstn)
            idle_cnt_q <= {`UIF_IDLE_CNT_W{1'b0}};
        else if (ce)
        begin
            if (bus_activity)
                idle_cnt_q <= {`UIF_IDLE_CNT_W{1'b0}};
            else if (!idle_ok)
                idle_cnt_q <= idle_cnt_q + 1'b1;
        end
    end

    assign turn_timeout = turn_arm_q && bit_tick && !response_seen
                          && (turn_cnt_q == `UIF_TURN_BITS);

    // arm on eop, count bit times until a response or time-out
    always @(posedge core_clk)
    begin
        if (!rstn)
        begin
            turn_cnt_q <= {`UIF_TURN_CNT_W{1'b0}};
            turn_arm_q <= 1'b0;
        end
        else if (ce)
        begin
            if (eop_seen)
            begin
                turn_cnt_q <= {`UIF_TURN_CNT_W{1'b0}};
                turn_arm_q <= 1'b1;
            end
            else if (response_seen || turn_timeout)
                turn_arm_q <= 1'b0;
            else if (turn_arm_q && bit_tick)
                turn_cnt_q <= turn_cnt_q + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // error set terms
    always @*
    begin
        err_set = `UIF_ZERO8;
        err_set[`UIF_ERR_STUFF_BIT] = bit_stuff_err;
        err_set[`UIF_ERR_BMX_BIT]   = bus_matrix_err;
        err_set[`UIF_ERR_DMA_BIT]   = dma_err;
        err_set[`UIF_ERR_TURN_BIT]  = turn_timeout;
        err_set[`UIF_ERR_ALIGN_BIT] = byte_align_err;
        err_set[`UIF_ERR_CRC16_BIT] = data_crc_err;
        // bit 1 meaning follows the mode
        if (host_mode_enable_q)
            err_set[`UIF_ERR_CRC5_BIT] = sof_count_zero && xfer_busy;
        else
            err_set[`UIF_ERR_CRC5_BIT] = token_crc_err;
        err_set[`UIF_ERR_PID_BIT]   = pid_check_err;
    end

    ////////////////////////////////////////////////////////////////////////
    // event set terms
    always @*
    begin
        evt_set = `UIF_ZERO8;
        // bit 0 is reset in device mode, detach in host mode
        if (host_mode_enable_q)
            evt_set[`UIF_EVT_RESET_BIT] = detach_det;
        else
            evt_set[`UIF_EVT_RESET_BIT] = bus_reset_det;
        // summary from enabled errors only
        evt_set[`UIF_EVT_ERR_BIT]    = |(err_set & err_en_q);
        evt_set[`UIF_EVT_SOF_BIT]    = sof_det;
        evt_set[`UIF_EVT_TOKEN_BIT]  = token_done;
        evt_set[`UIF_EVT_IDLE_BIT]   = idle_det;
        evt_set[`UIF_EVT_RESUME_BIT] = resume_det;
        evt_set[`UIF_EVT_ATTACH_BIT] = attach_det && host_mode_enable_q
                                       && idle_ok && !line_se0;
        evt_set[`UIF_EVT_STALL_BIT]  = stall_det;
    end

    ////////////////////////////////////////////////////////////////////////
    // write-one-to-clear decode
    assign wr_evt = reg_wr && (reg_addr == `UIF_OFF_EVT_FLAG);
    assign wr_err = reg_wr && (reg_addr == `UIF_OFF_ERR_FLAG);
    assign evt_clr = wr_evt ? reg_wdata[`UIF_FLAGS_W-1:0] : `UIF_ZERO8;
    assign err_clr = wr_err ? reg_wdata[`UIF_FLAGS_W-1:0] : `UIF_ZERO8;

    // sticky flags, one cell per bit
    genvar gi;
    generate
        for (gi = 0; gi < `UIF_FLAGS_W; gi = gi + 1)
        begin : g_flags
            // summary bit is read-only: software cannot clear it
            uif_flag_bit u_evt
            (
                .core_clk (core_clk),
                .rstn     (rstn),
                .ce       (ce),
                .set_in   (evt_set[gi]),
                .clr_in   ((gi == `UIF_EVT_ERR_BIT) ? 1'b0 : evt_clr[gi]),
                .flag_q   (evt_flag[gi])
            );
            uif_flag_bit u_err
            (
                .core_clk (core_clk),
                .rstn     (rstn),
                .ce       (ce),
                .set_in   (err_set[gi]),
                .clr_in   (err_clr[gi]),
                .flag_q   (err_flag[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // transaction status fifo
    reg  [`UIF_STAT_W-1:0]    fifo_mem [0:`UIF_FIFO_DEPTH-1];  // status entries
    reg  [`UIF_FIFO_PTR_W-1:0] wr_ptr_q;      // write pointer
    reg  [`UIF_FIFO_PTR_W-1:0] rd_ptr_q;      // read pointer
    reg  [`UIF_FIFO_CNT_W-1:0] fifo_cnt_q;    // occupancy
    wire                       fifo_push;     // new token status
    wire                       fifo_pop;      // token flag cleared

    assign fifo_push = token_done && (fifo_cnt_q != `UIF_FIFO_DEPTH);
    assign fifo_pop  = evt_clr[`UIF_EVT_TOKEN_BIT] && evt_flag[`UIF_EVT_TOKEN_BIT]
                       && (fifo_cnt_q != {`UIF_FIFO_CNT_W{1'b0}});

    // entries stored in order, popped by the token flag clear
    always @(posedge core_clk)
    begin
        if (!rstn)
        begin
            wr_ptr_q   <= {`UIF_FIFO_PTR_W{1'b0}};
            rd_ptr_q   <= {`UIF_FIFO_PTR_W{1'b0}};
            fifo_cnt_q <= {`UIF_FIFO_CNT_W{1'b0}};
        end
        else if (ce)
        begin
            if (fifo_push)
            begin
                fifo_mem[wr_ptr_q] <= token_stat;
                wr_ptr_q           <= wr_ptr_q + 1'b1;
            end
            if (fifo_pop)
                rd_ptr_q <= rd_ptr_q + 1'b1;
            if (fifo_push && !fifo_pop)
                fifo_cnt_q <= fifo_cnt_q + 1'b1;
            else if (fifo_pop && !fifo_push)
                fifo_cnt_q <= fifo_cnt_q - 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // writable registers
    always @(posedge core_clk)
    begin
        if (!rstn)
        begin
            evt_en_q           <= `UIF_ZERO8;
            err_en_q           <= `UIF_ZERO8;
            host_mode_enable_q <= 1'b0;
        end
        else if (ce && reg_wr)
        begin
            if (reg_addr == `UIF_OFF_EVT_EN)
                evt_en_q <= reg_wdata[`UIF_FLAGS_W-1:0];
            else if (reg_addr == `UIF_OFF_ERR_EN)
                err_en_q <= reg_wdata[`UIF_FLAGS_W-1:0];
            else if (reg_addr == `UIF_OFF_CTRL)
                host_mode_enable_q <= reg_wdata[`UIF_CTRL_HOST_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data, one cycle after the strobe; upper bits zero
    always @(posedge core_clk)
    begin
        if (!rstn)
            reg_rdata_q <= `UIF_ZERO32;
        else if (ce)
        begin
            reg_rdata_q <= `UIF_ZERO32;
            if (reg_rd)
            begin
                if (reg_addr == `UIF_OFF_EVT_FLAG)
                    reg_rdata_q[`UIF_FLAGS_W-1:0] <= evt_flag;
                else if (reg_addr == `UIF_OFF_EVT_EN)
                    reg_rdata_q[`UIF_FLAGS_W-1:0] <= evt_en_q;
                else if (reg_addr == `UIF_OFF_ERR_FLAG)
                    reg_rdata_q[`UIF_FLAGS_W-1:0] <= err_flag;
                else if (reg_addr == `UIF_OFF_ERR_EN)
                    reg_rdata_q[`UIF_FLAGS_W-1:0] <= err_en_q;
                else if (reg_addr == `UIF_OFF_CTRL)
                    reg_rdata_q[`UIF_CTRL_HOST_BIT] <= host_mode_enable_q;
                else if (reg_addr == `UIF_OFF_FIFO)
                    reg_rdata_q[`UIF_STAT_W-1:0] <= fifo_mem[rd_ptr_q];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt request and packet reject pulse
    always @(posedge core_clk)
    begin
        if (!rstn)
        begin
            usb_irq_request_q <= 1'b0;
            pkt_reject_q      <= 1'b0;
        end
        else if (ce)
        begin
            // error summary only passes through its own enable
            usb_irq_request_q <= |(evt_flag & evt_en_q);
            pkt_reject_q      <= bit_stuff_err || data_crc_err
                                 || (!host_mode_enable_q && token_crc_err);
        end
    end

endmodule
`default_nettype wire

// [include/uif_consts.vh]
// constants for the usb interrupt and error flag block
`ifndef UIF_CONSTS_VH
`define UIF_CONSTS_VH

// register offsets (byte addresses, chosen locally)
`define UIF_ADDR_W          8
`define UIF_OFF_EVT_FLAG    8'h00
`define UIF_OFF_EVT_EN      8'h04
`define UIF_OFF_ERR_FLAG    8'h08
`define UIF_OFF_ERR_EN      8'h0C
`define UIF_OFF_CTRL        8'h10
`define UIF_OFF_FIFO        8'h14

// event flag bit positions
`define UIF_EVT_RESET_BIT   0
`define UIF_EVT_ERR_BIT     1
`define UIF_EVT_SOF_BIT     2
`define UIF_EVT_TOKEN_BIT   3
`define UIF_EVT_IDLE_BIT    4
`define UIF_EVT_RESUME_BIT  5
`define UIF_EVT_ATTACH_BIT  6
`define UIF_EVT_STALL_BIT   7

// error flag bit positions
`define UIF_ERR_PID_BIT     0
`define UIF_ERR_CRC5_BIT    1
`define UIF_ERR_CRC16_BIT   2
`define UIF_ERR_ALIGN_BIT   3
`define UIF_ERR_TURN_BIT    4
`define UIF_ERR_DMA_BIT     5
`define UIF_ERR_BMX_BIT     6
`define UIF_ERR_STUFF_BIT   7

// control register bit
`define UIF_CTRL_HOST_BIT   0

// reset values and widths
`define UIF_FLAGS_W         8
`define UIF_ZERO8           8'h00
`define UIF_ZERO32          32'h00000000
`define UIF_ONE_BIT         1'b1

// attach qualification: bus idle time
`define UIF_IDLE_TIME_PS    2500000
`define UIF_CLK_PERIOD_PS   8000
`define UIF_IDLE_CYCLES     ((`UIF_IDLE_TIME_PS + `UIF_CLK_PERIOD_PS - 1) / `UIF_CLK_PERIOD_PS)
`define UIF_IDLE_CNT_W      9

// turnaround time-out in bit times
`define UIF_TURN_BITS       16
`define UIF_TURN_CNT_W      5

// status fifo
`define UIF_FIFO_DEPTH      4
`define UIF_FIFO_PTR_W      2
`define UIF_FIFO_CNT_W      3
`define UIF_STAT_W          6

`endif

// [sim/tb_uif_irq_flags.sv]
// self-checking bench for the usb interrupt and error flag block
`timescale 1ns/1ns
`default_nettype none
module tb_uif_irq_flags;
    logic        core_clk;  // 125 MHz clock
    logic        rstn;      // sync reset
    logic [7:0]  reg_addr;  // register address
    logic [31:0] reg_wdata; // write data
    logic        reg_wr;    // write strobe
    logic        reg_rd;    // read strobe
    logic        ce;        // clock enable
    wire  [31:0] reg_rdata_q;
    wire  [16:0] ev;
    wire  [5:0]  stat;
    wire  [3:0]  lv;
    wire         bit_tick, pkt_reject_q, host_mode_enable_q, usb_irq_request_q;
    int          mismatches = 0;
    int          comparisons = 0;
    logic [16:0] src [12];  // event source per row
    logic [7:0]  bits [12]; // flag expected per row
    logic [7:0]  a;
    logic [31:0] base;
    uif_irq_flags dut
    (
        .core_clk(core_clk), .rstn(rstn), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .pid_check_err(ev[0]), .token_crc_err(ev[1]), .data_crc_err(ev[2]),
        .byte_align_err(ev[3]), .eop_seen(ev[4]), .dma_err(ev[5]), .bus_matrix_err(ev[6]),
        .bit_stuff_err(ev[7]), .bus_reset_det(ev[8]), .detach_det(ev[9]), .attach_det(ev[10]),
        .resume_det(ev[11]), .idle_det(ev[12]), .sof_det(ev[13]), .stall_det(ev[14]),
        .token_done(ev[15]), .response_seen(ev[16]), .token_stat(stat), .bit_tick(bit_tick),
        .bus_activity(lv[0]), .line_se0(lv[1]), .sof_count_zero(lv[2]), .xfer_busy(lv[3]),
        .pkt_reject_q(pkt_reject_q), .host_mode_enable_q(host_mode_enable_q),
        .usb_irq_request_q(usb_irq_request_q)
    );
    uif_bus_model bus (.core_clk(core_clk), .ev(ev), .stat(stat), .lv(lv), .bit_tick(bit_tick));
    ////////////////////////////////////////////////////////////
    // clock
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= ad;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= ad;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        chk(reg_rdata_q, exp);
    endtask
    // write then read with no gap
    task automatic wrrd(input logic [7:0] ad, input logic [31:0] d, input logic [31:0] exp);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= ad;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        chk(reg_rdata_q, exp);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // watchdog, about twenty times the expected run
    initial
    begin
        #200000;
        mismatches++;
        print_verdict();
    end
    ////////////////////////////////////////////////////////////
    initial
    begin
        rstn = 1'b0;
        reg_addr = 8'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        ce = 1'b1;
        src = '{17'h1, 17'h2, 17'h4, 17'h8, 17'h20, 17'h40, 17'h80,
                17'h100, 17'h2000, 17'h1000, 17'h800, 17'h4000};
        bits = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h20, 8'h40, 8'h80,
                 8'h01, 8'h04, 8'h10, 8'h20, 8'h80};
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        for (int i = 0; i <= 32; i += 4)
            if (i != 20) rd(i[7:0], 32'h0);
        $display("reset values done");
        wrrd(8'h04, 32'hFFFFFFFF, 32'hFF);
        wrrd(8'h04, 32'h0, 32'h0);
        wrrd(8'h0C, 32'hFFFFFF5A, 32'h5A);
        wrrd(8'h0C, 32'h0, 32'h0);
        bus.fire(17'h1, 6'h0);
        rd(8'h08, 32'h01);
        rd(8'h00, 32'h0);
        wr(8'h08, 32'h01);
        wr(8'h0C, 32'hFF);
        $display("enables and masking done");
        for (int i = 0; i < 12; i++)
        begin
            a = (i < 7) ? 8'h08 : 8'h00;
            base = (i < 7) ? 32'h0 : 32'h2;
            bus.fire(src[i], 6'h0);
            rd(a, {24'h0, bits[i]} | base);
            wr(a, 32'h0);
            rd(a, {24'h0, bits[i]} | base);
            wr(a, {24'hFFFFFF, bits[i]});
            rd(a, base);
        end
        $display("flag table done");
        bus.fire(17'h10, 6'h0);
        repeat (140) @(posedge core_clk);
        rd(8'h08, 32'h0);
        repeat (60) @(posedge core_clk);
        rd(8'h08, 32'h10);
        wr(8'h08, 32'h10);
        bus.fire(17'h10, 6'h0);
        bus.fire(17'h10000, 6'h0);
        repeat (250) @(posedge core_clk);
        rd(8'h08, 32'h0);
        $display("turnaround done");
        wrrd(8'h04, 32'h02, 32'h02);
        chk({31'h0, usb_irq_request_q}, 32'h1);
        wrrd(8'h04, 32'h0, 32'h0);
        chk({31'h0, usb_irq_request_q}, 32'h0);
        $display("request done");
        wrrd(8'h10, 32'h1, 32'h1);
        bus.fire(17'h200, 6'h0);
        rd(8'h00, 32'h03);
        wr(8'h00, 32'h01);
        bus.fire(17'h100, 6'h0);
        rd(8'h00, 32'h02);
        bus.fire(17'h2, 6'h0);
        rd(8'h08, 32'h0);
        bus.lines(4'hC);
        bus.lines(4'h0);
        rd(8'h08, 32'h02);
        wr(8'h08, 32'h02);
        bus.lines(4'h1);
        bus.lines(4'h0);
        repeat (100) @(posedge core_clk);
        bus.fire(17'h400, 6'h0);
        rd(8'h00, 32'h02);
        repeat (320) @(posedge core_clk);
        bus.lines(4'h2);
        bus.fire(17'h400, 6'h0);
        rd(8'h00, 32'h02);
        bus.lines(4'h0);
        bus.fire(17'h400, 6'h0);
        rd(8'h00, 32'h42);
        wr(8'h00, 32'h40);
        $display("host mode done");
        wrrd(8'h10, 32'h0, 32'h0);
        bus.fire(17'h8000, 6'h15);
        bus.fire(17'h8000, 6'h2A);
        rd(8'h14, 32'h15);
        rd(8'h00, 32'h0A);
        wr(8'h00, 32'h08);
        rd(8'h14, 32'h2A);
        $display("status fifo done");
        // clock enable low: neither a write nor an event may land
        @(posedge core_clk);
        ce <= 1'b0;
        wr(8'h04, 32'h10);
        bus.fire(17'h1000, 6'h0);
        @(posedge core_clk);
        ce <= 1'b1;
        rd(8'h00, 32'h02);
        rd(8'h04, 32'h0);
        $display("clock enable done");
        print_verdict();
    end
endmodule
`default_nettype wire

// [sim/uif_bus_model.sv]
// behavioural usb line side: event pulses, line levels, bit ticks
`timescale 1ns/1ns
`default_nettype none
module uif_bus_model
#(
    parameter int TICK_DIV = 10 // core cycles per bit time
)
(
    input  wire logic        core_clk, // block clock
    output var  logic [16:0] ev,       // one-cycle event pulses
    output var  logic [5:0]  stat,     // status word with token done
    output var  logic [3:0]  lv,       // activity, se0, sof zero, busy
    output var  logic        bit_tick  // one pulse each bit time
);
    int div_q = 0; // bit time divider
    initial
    begin
        ev = 17'h0;
        stat = 6'h0;
        lv = 4'h0;
        bit_tick = 1'b0;
    end
    // free running bit time ticks
    always @(posedge core_clk)
    begin
        div_q <= (div_q == TICK_DIV - 1) ? 0 : div_q + 1;
        bit_tick <= (div_q == TICK_DIV - 1);
    end
    // one pulse; status word does not linger after it
    task automatic fire(input logic [16:0] v, input logic [5:0] s);
        @(posedge core_clk);
        ev <= v;
        stat <= s;
        @(posedge core_clk);
        ev <= 17'h0;
        stat <= ~s;
    endtask
    // line levels
    task automatic lines(input logic [3:0] v);
        @(posedge core_clk);
        lv <= v;
    endtask
endmodule
`default_nettype wire

// [sim/uif_irq_flags_sva.sv]
// port checker for the usb interrupt and error flag block
`timescale 1ns/1ns
`default_nettype none
module uif_chk
(
    input wire logic        core_clk,           // block clock
    input wire logic        rstn,               // sync reset, active low
    input wire logic        ce,                 // clock enable
    input wire logic [7:0]  reg_addr,           // register byte address
    input wire logic [31:0] reg_wdata,          // write data
    input wire logic        reg_wr,             // write strobe
    input wire logic        reg_rd,             // read strobe
    input wire logic [31:0] reg_rdata_q,        // read data
    input wire logic        bit_stuff_err,      // stuffing violation
    input wire logic        data_crc_err,       // data crc failure
    input wire logic        token_crc_err,      // token crc failure
    input wire logic        pkt_reject_q,       // packet dropped
    input wire logic        host_mode_enable_q, // host operation
    input wire logic        usb_irq_request_q   // merged request
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn || !ce);
    ////////////////////////////////////////////////////////////
    upper_zero_a: assert property (reg_rdata_q[31:8] == 24'h0)
        else $error("upper read bits not zero");
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata_q == 32'h0)
        else $error("read data without read strobe");
    stuff_reject_a: assert property (bit_stuff_err |=> pkt_reject_q)
        else $error("stuffed packet not dropped");
    crc16_reject_a: assert property (data_crc_err |=> pkt_reject_q)
        else $error("bad data crc packet not dropped");
    token_reject_a:
        assert property (token_crc_err && !host_mode_enable_q |=> pkt_reject_q)
        else $error("bad token crc not dropped");
    no_reject_a:
        assert property (!bit_stuff_err && !data_crc_err && !token_crc_err |=> !pkt_reject_q)
        else $error("packet dropped without cause");
    host_sel_a:
        assert property (reg_wr && reg_addr == 8'h10 |=> host_mode_enable_q == $past(reg_wdata[0]))
        else $error("host mode not taken from write");
    evt_en_rw_a:
        assert property (reg_wr && reg_addr == 8'h04 ##1 reg_rd && reg_addr == 8'h04
            |=> reg_rdata_q == {24'h0, $past(reg_wdata[7:0], 2)})
        else $error("event enable readback wrong");
    err_en_rw_a:
        assert property (reg_wr && reg_addr == 8'h0C ##1 reg_rd && reg_addr == 8'h0C
            |=> reg_rdata_q == {24'h0, $past(reg_wdata[7:0], 2)})
        else $error("error enable readback wrong");
    irq_off_a:
        assert property (reg_wr && reg_addr == 8'h04 && reg_wdata[7:0] == 8'h00
            |=> ##1 !usb_irq_request_q)
        else $error("request with all enables off");
endmodule
bind uif_irq_flags uif_chk u_chk
(
    .core_clk(core_clk), .rstn(rstn), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .bit_stuff_err(bit_stuff_err), .data_crc_err(data_crc_err),
    .token_crc_err(token_crc_err), .pkt_reject_q(pkt_reject_q),
    .host_mode_enable_q(host_mode_enable_q), .usb_irq_request_q(usb_irq_request_q)
);
`default_nettype wire
